// ---- pin_sync.sv ----
/*
  Two-flop synchroniser for a bus of pin inputs.
  Assumes the bus is sampled only once it has settled.
*/
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 18
) (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic [WIDTH-1:0] d, // Raw pin levels.
  output logic [WIDTH-1:0] q // Synchronised levels.
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // pin_sync

// ---- sram_host_defines.svh ----
/*
  Constants for the synchronous write-pulse and address-latch host.
  Assumes a 100 MHz system clock and an asynchronous 64K x 18 RAM
  with an on-chip transparent address latch on the far side.
*/
`ifndef SRAM_HOST_DEFINES_SVH
`define SRAM_HOST_DEFINES_SVH

// ------------------------------------------------------------------
// Widths and field positions
// ------------------------------------------------------------------
`define ADDR_W 16
`define LANE_W 9
`define LANES 2
`define NARROW_ADDR_BIT 16
`define AGE_W 8

// ------------------------------------------------------------------
// Clock and phase timing
// ------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define HIGH_PHASE_CYC 2
`define LOW_PHASE_CYC 2
`define SYNC_STAGES 2
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ------------------------------------------------------------------
// Far-side timing figures, in ns, and their cycle counts
// ------------------------------------------------------------------
`define ACCESS_FROM_GATE_RISE_NS 20
`define ADDR_ACCESS_NS 20
`define LATCH_ADDR_SETUP_NS 5
`define LATCH_ADDR_HOLD_NS 3
`define ACCESS_FROM_GATE_RISE_CYC `CEIL_CYC(`ACCESS_FROM_GATE_RISE_NS)
`define ADDR_ACCESS_CYC `CEIL_CYC(`ADDR_ACCESS_NS)
`define LATCH_ADDR_SETUP_CYC `CEIL_CYC(`LATCH_ADDR_SETUP_NS)
`define LATCH_ADDR_HOLD_CYC `CEIL_CYC(`LATCH_ADDR_HOLD_NS)

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RST_ALE 1'b1
`define RST_CTL_N 1'b1

`endif

// ---- sram_host_pkg.sv ----
/*
  Types shared by the host files: modes, request and pin bundles.
  Assumes sram_host_defines.svh is on the include path.
*/
`include "sram_host_defines.svh"

package sram_host_pkg;

  typedef enum logic [1:0] {
    ALE_FROM_WE, ALE_FROM_CE_OR_WE, ALE_TIED_HIGH
  } ale_mode_t;

  typedef enum logic [1:0] {
    CE_ALWAYS_ON, CE_STANDBY_IDLE, CE_BOUNDS_WRITE
  } ce_mode_t;

  typedef struct packed {
    ale_mode_t ale_mode;
    ce_mode_t ce_mode;
    logic narrow;
  } cfg_t;

  typedef struct packed {
    logic write;
    logic [`ADDR_W:0] addr;
    logic [`LANES*`LANE_W-1:0] wdata;
    logic [`LANES-1:0] be;
  } req_t;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [`LANES-1:0] sel_n;
    logic ale;
  } pins_t;

endpackage

// ---- sram_lane_model.sv ----
/*
  Behavioural model of the asynchronous two-lane RAM with its on-chip
  transparent address latch, answering with zero access delay.
  Assumes the bench resolves the shared data bus and feeds it to dq.
*/
`timescale 1ns/1ps
`include "sram_host_defines.svh"

module sram_lane_model (
  input wire logic [`ADDR_W-1:0] addr, // Address pins.
  input wire logic ce_n, // Chip enable, active low.
  input wire logic we_n, // Write enable, active low.
  input wire logic oe_n, // Output enable, active low.
  input wire logic [`LANES-1:0] sel_n, // Lane selects, active low.
  input wire logic ale, // Latch enable, high is transparent.
  input wire logic [`LANES*`LANE_W-1:0] dq, // Resolved data bus.
  output logic [`LANES*`LANE_W-1:0] q, // Data the RAM drives.
  output logic [`LANES-1:0] q_en // High per lane while driving.
);
  logic [`LANE_W-1:0] mem [`LANES][2**`ADDR_W];
  logic [`ADDR_W-1:0] lat_q;

  // The latch ignores chip enable, so it also runs in standby.
  always_latch begin
    if (ale) begin
      lat_q <= addr;
    end
  end

  always @* begin
    if (!ce_n && !we_n) begin
      for (int l = 0; l < `LANES; l++) begin
        if (!sel_n[l]) begin
          mem[l][lat_q] = dq[l*`LANE_W +: `LANE_W];
        end
      end
    end
  end

  always @* begin
    for (int l = 0; l < `LANES; l++) begin
      q_en[l] = !ce_n && we_n && !oe_n && !sel_n[l];
      q[l*`LANE_W +: `LANE_W] = mem[l][lat_q];
    end
  end
endmodule // sram_lane_model

// ---- sram_write_address_latch_tb.sv ----
/*
  Self-checking bench for the write-pulse and address-latch host.
  Assumes the lane model on the far side and a 100 MHz clock.
*/
`timescale 1ns/1ps
`include "sram_host_defines.svh"

module sram_write_address_latch_tb;
  localparam int DW = `LANES*`LANE_W;
  typedef struct packed {
    logic w;
    logic [16:0] a;
    logic [17:0] d;
    logic [1:0] be;
    logic [17:0] exp;
  } row_t;

  logic clk;
  logic sys_rst;
  sram_host_pkg::cfg_t cfg;
  logic req_valid;
  sram_host_pkg::req_t req;
  logic req_ready;
  logic rsp_valid;
  logic [DW-1:0] rsp_rdata;
  sram_host_pkg::pins_t pins;
  logic [DW-1:0] dq_o;
  logic dq_oe;
  wire [DW-1:0] bus;
  logic [DW-1:0] ram_q;
  logic [`LANES-1:0] ram_en;
  logic [DW-1:0] last_q = '0;
  logic prev_we;
  logic prev_ce;
  logic prev_ale;
  logic [`ADDR_W-1:0] prev_addr;
  int fail_count;
  int n_tests;

  // Address 5 is filled by the narrow pass; the rows never write it.
  row_t rows [7] = '{
    '{1'b0, 17'h00005, 18'h00000, 2'b11, 18'h15555},
    '{1'b1, 17'h01234, 18'h3ffff, 2'b11, 18'h00000},
    '{1'b1, 17'h01234, 18'h00000, 2'b01, 18'h00000},
    '{1'b1, 17'h0ffff, 18'h15555, 2'b11, 18'h00000},
    '{1'b1, 17'h0ffff, 18'h00000, 2'b10, 18'h00000},
    '{1'b0, 17'h01234, 18'h00000, 2'b11, 18'h3fe00},
    '{1'b0, 17'h0ffff, 18'h00000, 2'b11, 18'h00155}
  };
  sram_host_pkg::cfg_t cfgs [4] = '{
    '{sram_host_pkg::ALE_FROM_WE, sram_host_pkg::CE_ALWAYS_ON, 1'b1},
    '{sram_host_pkg::ALE_FROM_WE, sram_host_pkg::CE_ALWAYS_ON, 1'b0},
    '{sram_host_pkg::ALE_FROM_CE_OR_WE, sram_host_pkg::CE_BOUNDS_WRITE, 1'b0},
    '{sram_host_pkg::ALE_TIED_HIGH, sram_host_pkg::CE_STANDBY_IDLE, 1'b0}
  };

  sram_write_host u_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .cfg(cfg),
    .req_valid(req_valid),
    .req(req),
    .req_ready(req_ready),
    .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata),
    .pins(pins),
    .dq_o(dq_o),
    .dq_oe(dq_oe),
    .dq_i(bus)
  );

  sram_lane_model u_ram (
    .addr(pins.addr),
    .ce_n(pins.ce_n),
    .we_n(pins.we_n),
    .oe_n(pins.oe_n),
    .sel_n(pins.sel_n),
    .ale(pins.ale),
    .dq(bus),
    .q(ram_q),
    .q_en(ram_en)
  );

  // ---------------------------------------------------------------
  // Data bus resolution
  // ---------------------------------------------------------------
  // A lane nobody drives shows the inverse of its last level, so a
  // stale value can never pass for read data. The 1 ns lag stands
  // for board delay and keeps data behind the end of a write.
  assign #1 bus[8:0] = dq_oe ? dq_o[8:0] :
    (ram_en[0] ? ram_q[8:0] : ~last_q[8:0]);
  assign #1 bus[17:9] = dq_oe ? dq_o[17:9] :
    (ram_en[1] ? ram_q[17:9] : ~last_q[17:9]);

  always @(posedge clk) begin
    last_q <= bus;
  end

  initial begin
    clk = 1'b0;
    forever begin
      #5 clk = ~clk;
    end
  end

  // ---------------------------------------------------------------
  // Compare and verdict tasks
  // ---------------------------------------------------------------
  task automatic cmp_data(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_pins(input sram_host_pkg::pins_t got,
                          input sram_host_pkg::pins_t exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------
  // Mode changes happen only under reset, so the pin checks below
  // never see a half-switched configuration.
  task automatic do_reset(input sram_host_pkg::cfg_t c);
    sys_rst = 1'b1;
    cfg = c;
    req_valid = 1'b0;
    repeat (12) @(negedge clk);
    cmp_pins(pins, '{16'h0000, 1'b1, 1'b1, 1'b1, 2'b11, 1'b1});
    cmp_bit(dq_oe | req_ready | rsp_valid, 1'b0);
    sys_rst = 1'b0;
  endtask

  // Called at a falling edge; returns at the falling edge after the
  // take, with valid still up so back-to-back calls stay seamless.
  task automatic send(input row_t r);
    int i;
    req_valid = 1'b1;
    req = '{r.w, r.a, r.d, r.be};
    for (i = 0; i < 40 && req_ready !== 1'b1; i++) begin
      @(negedge clk);
    end
    if (i == 40) begin
      fail_count++;
      print_verdict();
    end
    @(negedge clk);
  endtask

  task automatic run_row(input row_t r);
    int i;
    send(r);
    if (!r.w) begin
      req_valid = 1'b0;
      for (i = 0; i < 100 && rsp_valid !== 1'b1; i++) begin
        @(negedge clk);
      end
      if (i == 100) begin
        fail_count++;
        print_verdict();
      end
      cmp_data(rsp_rdata, r.exp);
    end
  endtask

  // ---------------------------------------------------------------
  // Pin monitor
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    if (!sys_rst) begin
      if (pins.we_n === 1'b0) begin
        cmp_bit(pins.oe_n & dq_oe, 1'b1);
      end
      if (cfg.ale_mode == sram_host_pkg::ALE_FROM_WE) begin
        cmp_bit(pins.ale, prev_we);
      end else if (cfg.ale_mode == sram_host_pkg::ALE_FROM_CE_OR_WE) begin
        cmp_bit(pins.ale, prev_ce | prev_we);
      end else begin
        cmp_bit(pins.ale, 1'b1);
      end
      if (prev_ale === 1'b1 && pins.ale === 1'b0) begin
        cmp_data({2'b00, pins.addr}, {2'b00, prev_addr});
      end
    end
    prev_we = pins.we_n;
    prev_ce = pins.ce_n;
    prev_ale = pins.ale;
    prev_addr = pins.addr;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    fail_count = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    cfg = cfgs[0];
    req_valid = 1'b0;
    req = '0;
    @(negedge clk);
    do_reset(cfgs[0]);
    // Narrow mode: the extra address bit picks the lane.
    run_row('{1'b1, 17'h10005, 18'h000aa, 2'b00, 18'h0});
    run_row('{1'b1, 17'h00005, 18'h00155, 2'b00, 18'h0});
    run_row('{1'b0, 17'h10005, 18'h0, 2'b00, 18'h000aa});
    run_row('{1'b0, 17'h00005, 18'h0, 2'b00, 18'h00155});
    for (int p = 1; p < 4; p++) begin
      do_reset(cfgs[p]);
      for (int r = 0; r < 7; r++) begin
        run_row(rows[r]);
      end
    end
    print_verdict();
  end
endmodule // sram_write_address_latch_tb

// ---- sram_write_host.sv ----
/*
  Synchronous host that drives an asynchronous 64K x 18 RAM with an
  on-chip address latch: forms the write pulse from the low clock
  phase and drives the latch enable so the address outlasts it.
  Assumes the RAM pins are wired straight to the pins bundle and the
  dq pins resolve from dq_o and dq_oe outside this module.
*/
`timescale 1ns/1ps
`include "sram_host_defines.svh"

module sram_write_host #(
  parameter int HIGH_CYC = `HIGH_PHASE_CYC,
  parameter int LOW_CYC = `LOW_PHASE_CYC
) (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input sram_host_pkg::cfg_t cfg, // Static mode settings.
  input wire logic req_valid, // Request offered.
  input sram_host_pkg::req_t req, // Request contents.
  output logic req_ready, // Request taken on this edge if valid.
  output logic rsp_valid, // Read data valid, one cycle.
  output logic [`LANES*`LANE_W-1:0] rsp_rdata, // Read data.
  output sram_host_pkg::pins_t pins, // RAM control and address pins.
  output logic [`LANES*`LANE_W-1:0] dq_o, // Data driven to the RAM.
  output logic dq_oe, // High while the host drives dq.
  input wire logic [`LANES*`LANE_W-1:0] dq_i // Data pins as seen.
);

  localparam int DW = `LANES * `LANE_W;
  localparam logic [`AGE_W-1:0] AGE_MAX = '1;
  localparam logic [`AGE_W-1:0] LEA_WAIT =
    `AGE_W'(`ACCESS_FROM_GATE_RISE_CYC + `SYNC_STAGES);
  localparam logic [`AGE_W-1:0] AA_WAIT =
    `AGE_W'(`ADDR_ACCESS_CYC + `SYNC_STAGES);

  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} state_t;

  // ----------------------------------------------------------------
  // Phase source and pin synchroniser
  // ----------------------------------------------------------------
  logic last;
  logic last_soon;
  logic low_now;
  logic low_soon;
  logic [DW-1:0] dq_s;

  sys_phase_gen #(
    .HIGH_CYC(HIGH_CYC),
    .LOW_CYC(LOW_CYC)
  ) u_phase (
    .clk(clk),
    .sys_rst(sys_rst),
    .last(last),
    .last_soon(last_soon),
    .low_now(low_now),
    .low_soon(low_soon)
  );

  pin_sync #(
    .WIDTH(DW)
  ) u_dq_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(dq_i),
    .q(dq_s)
  );

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  state_t state_q;
  state_t state_d;
  logic take;
  logic rd_ok;
  logic [`AGE_W-1:0] addr_age_q;
  logic [`AGE_W-1:0] ale_age_q;
  logic [`ADDR_W:0] full_addr_q;

  // A request is only taken at the end of a system cycle, so the new
  // address appears at the clock rise, well before the low phase.
  assign take = req_valid && req_ready && last;
  // Reads right after a write must see the latch open long enough.
  assign rd_ok = state_q == ST_READ && last &&
                 addr_age_q >= AA_WAIT && ale_age_q >= LEA_WAIT;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = req.write ? ST_WRITE : ST_READ;
        end
      end
      ST_WRITE: begin
        if (take) begin
          state_d = req.write ? ST_WRITE : ST_READ;
        end else if (last) begin
          state_d = ST_IDLE;
        end
      end
      ST_READ: begin
        if (rd_ok) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= last_soon &&
                   (state_d == ST_IDLE || state_d == ST_WRITE);
    end
  end

  // ----------------------------------------------------------------
  // Address, selects and write data, loaded at the clock rise
  // ----------------------------------------------------------------
  logic [`LANES-1:0] sel_n_q;
  logic narrow_hi;

  assign narrow_hi = req.addr[`NARROW_ADDR_BIT];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      full_addr_q <= '0;
      sel_n_q <= '1;
      dq_o <= '0;
    end else if (take) begin
      full_addr_q <= req.addr;
      if (cfg.narrow) begin
        sel_n_q <= {!narrow_hi, narrow_hi};
        dq_o <= {2{req.wdata[`LANE_W-1:0]}};
      end else begin
        sel_n_q <= ~req.be;
        dq_o <= req.wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_age_q <= '0;
    end else if (take) begin
      addr_age_q <= '0;
    end else if (addr_age_q != AGE_MAX) begin
      addr_age_q <= addr_age_q + `AGE_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Write pulse, chip enable, output enable and bus drive
  // ----------------------------------------------------------------
  logic we_n_q;
  logic ce_n_q;
  logic oe_n_q;
  logic ale_q;
  logic wr_next;

  assign wr_next = state_d == ST_WRITE;

  // The write pulse is the low clock phase gated by the write state;
  // it ends at the rise, on the same clock edge that loads any new address.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      we_n_q <= `RST_CTL_N;
    end else if (cfg.ce_mode == sram_host_pkg::CE_BOUNDS_WRITE) begin
      we_n_q <= !wr_next;
    end else begin
      we_n_q <= !(wr_next && low_soon);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ce_n_q <= `RST_CTL_N;
    end else begin
      unique case (cfg.ce_mode)
        sram_host_pkg::CE_ALWAYS_ON: ce_n_q <= 1'b0;
        sram_host_pkg::CE_STANDBY_IDLE: ce_n_q <= state_d == ST_IDLE;
        sram_host_pkg::CE_BOUNDS_WRITE: begin
          ce_n_q <= !(state_d == ST_READ || (wr_next && low_soon));
        end
        default: ce_n_q <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oe_n_q <= `RST_CTL_N;
      dq_oe <= 1'b0;
    end else begin
      oe_n_q <= state_d != ST_READ;
      dq_oe <= wr_next;
    end
  end

  // ----------------------------------------------------------------
  // Latch enable
  // ----------------------------------------------------------------
  // The register stage is the delay that keeps the enable behind the
  // write strobe, so the latch closes after the pulse starts and
  // reopens only after it ends. The cost is a later access on reads.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ale_q <= `RST_ALE;
    end else begin
      unique case (cfg.ale_mode)
        sram_host_pkg::ALE_FROM_WE: ale_q <= we_n_q;
        sram_host_pkg::ALE_FROM_CE_OR_WE: begin
          ale_q <= we_n_q | ce_n_q;
        end
        sram_host_pkg::ALE_TIED_HIGH: ale_q <= 1'b1;
        default: ale_q <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ale_age_q <= '0;
    end else if (!ale_q) begin
      ale_age_q <= '0;
    end else if (ale_age_q != AGE_MAX) begin
      ale_age_q <= ale_age_q + `AGE_W'(1);
    end
  end

  assign pins = '{addr: full_addr_q[`ADDR_W-1:0], ce_n: ce_n_q,
                  we_n: we_n_q, oe_n: oe_n_q, sel_n: sel_n_q,
                  ale: ale_q};

  // ----------------------------------------------------------------
  // Read return
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= rd_ok;
      if (rd_ok) begin
        if (cfg.narrow) begin
          rsp_rdata <= {{`LANE_W{1'b0}},
                        full_addr_q[`NARROW_ADDR_BIT] ?
                        dq_s[DW-1:`LANE_W] : dq_s[`LANE_W-1:0]};
        end else begin
          rsp_rdata <= dq_s;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic we_mode;
  logic wr_pulse;
  logic hold_mode;
  assign we_mode = cfg.ce_mode != sram_host_pkg::CE_BOUNDS_WRITE;
  // The RAM writes only while both enables are low, so that overlap is
  // the write pulse whichever of the two bounds it.
  assign wr_pulse = !we_n_q && !ce_n_q;
  assign hold_mode = cfg.ale_mode == sram_host_pkg::ALE_FROM_CE_OR_WE ||
                     (cfg.ale_mode == sram_host_pkg::ALE_FROM_WE && we_mode);

  sequence s_high_half;
    we_n_q [*2];
  endsequence

  sequence s_low_half;
    !we_n_q [*2];
  endsequence

  a_pulse_shape: assert property (
    (take && req.write && we_mode && HIGH_CYC == 2 && LOW_CYC == 2)
    |=> s_high_half ##1 s_low_half ##1 we_n_q)
    else $error("write pulse not in low phase");

  a_pulse_low_phase: assert property (
    (we_mode && !we_n_q) |-> low_now)
    else $error("write strobe outside low phase");

  a_addr_under_we: assert property (
    wr_pulse |-> $stable(full_addr_q))
    else $error("address moved during write pulse");

  a_ale_trails_we: assert property (
    cfg.ale_mode == sram_host_pkg::ALE_FROM_WE && $changed(we_n_q)
    |=> ale_q == $past(we_n_q) && ale_q != $past(ale_q))
    else $error("latch enable not one clk behind write");

  a_ale_or_gate: assert property (
    cfg.ale_mode == sram_host_pkg::ALE_FROM_CE_OR_WE
    |=> ale_q == ($past(we_n_q) | $past(ce_n_q)))
    else $error("latch enable not or of enables");

  // The address may move on the edge after the latch closes, since the
  // closed latch hides it; it must not move on the closing edge or on the one before.
  a_latch_hold: assert property (
    $fell(ale_q) |-> $stable(full_addr_q) &&
                     full_addr_q == $past(full_addr_q, 2))
    else $error("latch setup or hold broken");

  a_hold_after_rise: assert property (
    hold_mode && $fell(wr_pulse) |-> !ale_q ##1 ale_q)
    else $error("latch reopened before write end");

  a_write_bus: assert property (
    !we_n_q |-> oe_n_q && dq_oe)
    else $error("write without bus drive");

  a_latch_open: assert property (
    cfg.ale_mode == sram_host_pkg::ALE_TIED_HIGH [*2] |-> ale_q)
    else $error("latch enable not held high");

  // Four clocks of open latch and steady address cover the access time
  // plus the synchroniser, counted here without the age counters.
  a_read_wait: assert property (
    rsp_valid |-> $past(ale_q, 2) && $past(ale_q, 3) &&
                  $past(ale_q, 4) && $past(ale_q, 5) &&
                  full_addr_q == $past(full_addr_q, 5))
    else $error("read returned before access time");

  a_narrow_sel: assert property (
    cfg.narrow && state_q != ST_IDLE && $past(cfg.narrow)
    |-> sel_n_q != 2'h0 && sel_n_q != 2'h3)
    else $error("narrow mode selects both lanes");

  a_ce_on: assert property (
    cfg.ce_mode == sram_host_pkg::CE_ALWAYS_ON [*2] |-> !ce_n_q)
    else $error("chip enable dropped in always-on mode");

endmodule // sram_write_host

// ---- sys_phase_gen.sv ----
/*
  Divides clk into a system cycle with a high and a low phase.
  Assumes one clock domain and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`include "sram_host_defines.svh"

module sys_phase_gen #(
  parameter int HIGH_CYC = `HIGH_PHASE_CYC,
  parameter int LOW_CYC = `LOW_PHASE_CYC
) (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  output logic last, // Final clk of the system cycle.
  output logic last_soon, // Next clk is the final one.
  output logic low_now, // Current clk lies in the low phase.
  output logic low_soon // Next clk lies in the low phase.
);

  localparam int PERIOD = HIGH_CYC + LOW_CYC;

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  assign last = cnt_q == 8'(PERIOD - 1);
  assign last_soon = cnt_q == 8'(PERIOD - 2);
  assign low_now = cnt_q >= 8'(HIGH_CYC);
  assign cnt_d = last ? 8'h00 : cnt_q + 8'h01;
  assign low_soon = cnt_d >= 8'(HIGH_CYC);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // sys_phase_gen
